/* rtl/irig_timecode_encoder.sv */
// Time-code frame generator with APB registers and pulse-width output.
//
// How it works
// - One format at a time, set by register.
// - Optional level-shifted copy of the code.
// - Basic mode sends BCD time, 100 pps.
// - Basic BCD-only format selected after reset.
// - Binary seconds of day from position 80.
// - Extended mode adds control-bit status fields.
// - Year units P50-53, P54 zero, tens P55-58.
// - Leap pending set 59 seconds before.
// - P61 low adds, high deletes second.
// - DST pending one second early; P63 active.
// - Offset sign P64, hours P65-P68.
// - P70 flags extra half hour offset.
// - Quality code in P71 through P74.
// - Quality code mapped from time error.
// - P75 odd parity; P76-P78 zero.
// - NASA mode sends 100-bit frame.
// - Short mode sends 25-bit time frame.
`timescale 1ns/1ns
module irig_timecode_encoder
  import itce_pkg::*;
#(
  parameter int PERIOD_CYC = SYM_PERIOD_US * (CLK_HZ / US_PER_S),
  parameter int ZERO_CYC = SYM_ZERO_US * (CLK_HZ / US_PER_S),
  parameter int ONE_CYC = SYM_ONE_US * (CLK_HZ / US_PER_S),
  parameter int MARK_CYC = SYM_MARK_US * (CLK_HZ / US_PER_S)
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pps_in,
  input wire logic [31:0] time_error_ns,
  input wire logic ever_synced,
  output logic modulated_code_output,
  output logic dc_code_output
);

  // ****************************************************************
  // Register bus
  // ****************************************************************
  itce_fmt_t fmt_q;
  logic dc_en_q;
  logic [5:0] sec_q;
  logic [5:0] min_q;
  logic [4:0] hr_q;
  logic [8:0] day_q;
  logic [6:0] yr_q;
  logic leap_del_q;
  logic dst_on_q;
  logic ofs_neg_q;
  logic [3:0] ofs_hr_q;
  logic ofs_half_q;
  logic [CNTR_W-1:0] leap_cnt_q;
  logic [CNTR_W-1:0] dst_cnt_q;
  logic [3:0] qual_q;
  logic [6:0] idx_q;
  logic active_q;
  logic access_start;
  logic wr_en;
  logic hit;
  logic [31:0] rd_c;

  assign access_start = psel & penable & ~pready;
  assign wr_en = psel & penable & pwrite & pready;

  // Address decode for reads; an unmapped offset answers zero and an error.
  always_comb begin
    rd_c = '0;
    hit = 1'b1;
    if (paddr == OFS_CTRL) begin
      rd_c[CTRL_FMT_LSB +: 3] = fmt_q;
      rd_c[CTRL_DC_BIT] = dc_en_q;
    end else if (paddr == OFS_TIME) begin
      rd_c[TIME_SEC_LSB +: 6] = sec_q;
      rd_c[TIME_MIN_LSB +: 6] = min_q;
      rd_c[TIME_HR_LSB +: 5] = hr_q;
    end else if (paddr == OFS_DATE) begin
      rd_c[DATE_DAY_LSB +: 9] = day_q;
      rd_c[DATE_YR_LSB +: 7] = yr_q;
    end else if (paddr == OFS_LOCAL) begin
      rd_c[LOC_LEAP_DEL_BIT] = leap_del_q;
      rd_c[LOC_DST_ON_BIT] = dst_on_q;
      rd_c[LOC_NEG_BIT] = ofs_neg_q;
      rd_c[LOC_OFS_HR_LSB +: 4] = ofs_hr_q;
      rd_c[LOC_HALF_BIT] = ofs_half_q;
    end else if (paddr == OFS_LEAP) begin
      rd_c[CNTR_W-1:0] = leap_cnt_q;
    end else if (paddr == OFS_DST) begin
      rd_c[CNTR_W-1:0] = dst_cnt_q;
    end else if (paddr == OFS_STAT) begin
      rd_c[6:0] = idx_q;
      rd_c[STAT_ACT_BIT] = active_q;
      rd_c[STAT_QUAL_LSB +: 4] = qual_q;
    end else begin
      hit = 1'b0;
    end
  end

  // One wait state: data and pready are registered, so every access takes two cycles.
  always_ff @(posedge mclk) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= access_start;
      if (access_start) begin
        prdata <= pwrite ? '0 : rd_c;
        pslverr <= ~hit;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      fmt_q <= FMT_RST;
      dc_en_q <= 1'b0;
    end else if (wr_en && paddr == OFS_CTRL) begin
      fmt_q <= itce_fmt_t'(pwdata[CTRL_FMT_LSB +: 3]);
      dc_en_q <= pwdata[CTRL_DC_BIT];
    end
  end

  // Software loads the time of the coming second before its edge.
  always_ff @(posedge mclk) begin
    if (rst) begin
      sec_q <= '0;
      min_q <= '0;
      hr_q <= '0;
      day_q <= '0;
      yr_q <= '0;
    end else if (wr_en && paddr == OFS_TIME) begin
      sec_q <= pwdata[TIME_SEC_LSB +: 6];
      min_q <= pwdata[TIME_MIN_LSB +: 6];
      hr_q <= pwdata[TIME_HR_LSB +: 5];
    end else if (wr_en && paddr == OFS_DATE) begin
      day_q <= pwdata[DATE_DAY_LSB +: 9];
      yr_q <= pwdata[DATE_YR_LSB +: 7];
    end
  end

  // Local offset, leap direction and daylight-saving state.
  always_ff @(posedge mclk) begin
    if (rst) begin
      leap_del_q <= 1'b0;
      dst_on_q <= 1'b0;
      ofs_neg_q <= 1'b0;
      ofs_hr_q <= '0;
      ofs_half_q <= 1'b0;
    end else if (wr_en && paddr == OFS_LOCAL) begin
      leap_del_q <= pwdata[LOC_LEAP_DEL_BIT];
      dst_on_q <= pwdata[LOC_DST_ON_BIT];
      ofs_neg_q <= pwdata[LOC_NEG_BIT];
      ofs_hr_q <= pwdata[LOC_OFS_HR_LSB +: 4];
      ofs_half_q <= pwdata[LOC_HALF_BIT];
    end
  end

  // Countdowns in seconds to the next leap and DST change; a write wins over a tick.
  always_ff @(posedge mclk) begin
    if (rst) begin
      leap_cnt_q <= '0;
      dst_cnt_q <= '0;
    end else begin
      if (wr_en && paddr == OFS_LEAP) begin
        leap_cnt_q <= pwdata[CNTR_W-1:0];
      end else if (pps_in && leap_cnt_q != '0) begin
        leap_cnt_q <= leap_cnt_q - 1'b1;
      end
      if (wr_en && paddr == OFS_DST) begin
        dst_cnt_q <= pwdata[CNTR_W-1:0];
      end else if (pps_in && dst_cnt_q != '0) begin
        dst_cnt_q <= dst_cnt_q - 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || !ever_synced) begin
      qual_q <= QUAL_BAD;
    end else if (time_error_ns < ERR_1US_NS) begin
      qual_q <= QUAL_1US;
    end else if (time_error_ns < ERR_10US_NS) begin
      qual_q <= QUAL_10US;
    end else if (time_error_ns < ERR_100US_NS) begin
      qual_q <= QUAL_100US;
    end else if (time_error_ns < ERR_1MS_NS) begin
      qual_q <= QUAL_1MS;
    end else if (time_error_ns < ERR_10MS_NS) begin
      qual_q <= QUAL_10MS;
    end else begin
      qual_q <= QUAL_BAD;
    end
  end

  // ****************************************************************
  // Frame assembly
  // ****************************************************************
  logic [FRAME_LEN-1:0] long_d;
  logic [SHORT_LEN-1:0] short_d;
  logic [FRAME_LEN-1:0] frame_q;
  logic [SOD_W-1:0] sod_c;
  logic [11:0] bs;
  logic [11:0] bm;
  logic [11:0] bh;
  logic [11:0] bd;
  logic [11:0] by;

  assign bs = itce_bcd(9'(sec_q));
  assign bm = itce_bcd(9'(min_q));
  assign bh = itce_bcd(9'(hr_q));
  assign bd = itce_bcd(day_q);
  assign by = itce_bcd(9'(yr_q));
  assign sod_c = SOD_W'(sec_q) + SOD_W'(min_q) * SEC_PER_MIN + SOD_W'(hr_q) * SEC_PER_HR;

  always_comb begin
    long_d = '0;
    long_d[POS_SEC_U +: 4] = bs[3:0];
    long_d[POS_SEC_T +: 3] = bs[6:4];
    long_d[POS_MIN_U +: 4] = bm[3:0];
    long_d[POS_MIN_T +: 3] = bm[6:4];
    long_d[POS_HR_U +: 4] = bh[3:0];
    long_d[POS_HR_T +: 2] = bh[5:4];
    long_d[POS_DAY_U +: 4] = bd[3:0];
    long_d[POS_DAY_T +: 4] = bd[7:4];
    long_d[POS_DAY_H +: 2] = bd[9:8];
    if (fmt_q == FMT_B123 || fmt_q == FMT_B120) begin
      long_d[POS_SOD_LO +: SOD_LO_W] = sod_c[SOD_LO_W-1:0];
      long_d[POS_SOD_HI +: SOD_W-SOD_LO_W] = sod_c[SOD_W-1:SOD_LO_W];
    end
    if (fmt_q == FMT_B120) begin
      long_d[POS_YR_U +: 4] = by[3:0];
      long_d[POS_YR_T +: 4] = by[7:4];
      long_d[POS_LEAP_PEND] = (leap_cnt_q != '0) && (leap_cnt_q <= LEAP_WARN_S);
      long_d[POS_LEAP_DEL] = leap_del_q;
      long_d[POS_DST_PEND] = (dst_cnt_q == DST_WARN_S);
      long_d[POS_DST_ON] = dst_on_q;
      long_d[POS_OFS_SIGN] = ofs_neg_q;
      long_d[POS_OFS_HR +: 4] = ofs_hr_q;
      long_d[POS_OFS_HALF] = ofs_half_q;
      long_d[POS_QUAL +: 4] = qual_q;
      long_d[POS_PARITY] = ~(^long_d[POS_PARITY-1:0]);
    end
  end

  always_comb begin
    short_d = '0;
    short_d[SH_SEC +: 7] = bs[6:0];
    short_d[SH_MIN +: 7] = bm[6:0];
    short_d[SH_HR +: 6] = bh[5:0];
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      frame_q <= '0;
    end else if (pps_in) begin
      frame_q <= (fmt_q == FMT_SHORT) ? FRAME_LEN'(short_d) : long_d;
    end
  end

  // ****************************************************************
  // Symbol builder and buffer
  // ****************************************************************
  logic [6:0] last_c;
  logic marker_c;
  itce_sym_t sym_c;
  logic push_valid;
  logic push_ready;
  logic pop_valid;
  logic pop_ready;
  logic [1:0] pop_data;

  assign last_c = (fmt_q == FMT_SHORT) ? 7'(SHORT_LEN - 1) : 7'(FRAME_LEN - 1);
  assign push_valid = active_q & ~pps_in;

  always_comb begin
    marker_c = (idx_q == '0);
    if (fmt_q != FMT_SHORT && (idx_q % MARK_STEP) == MARK_PHASE) begin
      marker_c = 1'b1;
    end
    if (marker_c) begin
      sym_c = SYM_MARK;
    end else begin
      sym_c = frame_q[idx_q] ? SYM_ONE : SYM_ZERO;
    end
  end

  // A new second restarts the frame; a full buffer simply holds the builder.
  always_ff @(posedge mclk) begin
    if (rst) begin
      idx_q <= '0;
      active_q <= 1'b0;
    end else if (pps_in) begin
      idx_q <= '0;
      active_q <= 1'b1;
    end else if (push_valid && push_ready) begin
      idx_q <= idx_q + 1'b1;
      if (idx_q == last_c) begin
        active_q <= 1'b0;
      end
    end
  end

  itce_sym_fifo #(
    .WIDTH(2),
    .DEPTH(2)
  ) u_fifo (
    .mclk(mclk),
    .rst(rst),
    .flush(pps_in),
    .in_valid(push_valid),
    .in_data(sym_c),
    .in_ready(push_ready),
    .out_valid(pop_valid),
    .out_data(pop_data),
    .out_ready(pop_ready)
  );

  // ****************************************************************
  // Pulse-width serializer
  // ****************************************************************
  itce_state_t state_q;
  itce_state_t state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] width_q;
  logic [CNT_W-1:0] width_d;
  logic [CNT_W-1:0] new_width;

  always_comb begin
    case (itce_sym_t'(pop_data))
      SYM_ONE: new_width = CNT_W'(ONE_CYC);
      SYM_MARK: new_width = CNT_W'(MARK_CYC);
      default: new_width = CNT_W'(ZERO_CYC);
    endcase
  end

  // High for the symbol's width, low for the rest of the bit period.
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q + 1'b1;
    width_d = width_q;
    pop_ready = 1'b0;
    case (state_q)
      ST_IDLE: begin
        cnt_d = '0;
        if (pop_valid) begin
          pop_ready = 1'b1;
          width_d = new_width;
          state_d = ST_HIGH;
        end
      end
      ST_HIGH: begin
        if (cnt_q == width_q - 1'b1) begin
          state_d = ST_LOW;
        end
      end
      ST_LOW: begin
        if (cnt_q == CNT_W'(PERIOD_CYC - 1)) begin
          cnt_d = '0;
          pop_ready = pop_valid;
          width_d = new_width;
          state_d = pop_valid ? ST_HIGH : ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (pps_in) begin
      state_d = ST_IDLE;
      pop_ready = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      width_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      width_q <= width_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      modulated_code_output <= 1'b0;
      dc_code_output <= 1'b0;
    end else begin
      modulated_code_output <= (state_d == ST_HIGH);
      dc_code_output <= (state_d == ST_HIGH) & dc_en_q;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence s_second_edge;
    pps_in ##1 !pps_in [*2];
  endsequence

  sequence s_envelope_up;
    modulated_code_output;
  endsequence

  a_fmt_after_reset: assert property ($fell(rst) |-> fmt_q == FMT_B122)
    else $error("format not basic after reset");
  a_dc_gated: assert property (!dc_en_q |=> !dc_code_output)
    else $error("dc output active while disabled");
  a_frame_align: assert property (s_second_edge |=> s_envelope_up)
    else $error("frame edge not aligned to second");
  a_marker_place: assert property (fmt_q != FMT_SHORT && push_valid && push_ready
      && idx_q == 7'(POS_LEAP_PEND - 1) |-> sym_c == SYM_MARK)
    else $error("missing marker before position 60");
  a_year_gap: assert property (pps_in && fmt_q == FMT_B120 |=> !frame_q[POS_YR_U + 4])
    else $error("year gap bit not zero");
  a_leap_warn: assert property (pps_in && fmt_q == FMT_B120 && leap_cnt_q == LEAP_WARN_S
      |=> frame_q[POS_LEAP_PEND])
    else $error("leap pending not set");
  a_parity_odd: assert property (pps_in && fmt_q == FMT_B120
      |=> ^frame_q[POS_PARITY:0])
    else $error("control parity not odd");
  a_sod_low: assert property (pps_in && fmt_q == FMT_B123
      |=> frame_q[POS_SOD_LO +: SOD_LO_W] == $past(sod_c[SOD_LO_W-1:0]))
    else $error("binary seconds misplaced");
  a_quality_fine: assert property (ever_synced && time_error_ns < ERR_1US_NS
      ##1 ever_synced |-> qual_q == QUAL_1US)
    else $error("quality code wrong for fine error");

endmodule : irig_timecode_encoder

/* rtl/itce_pkg.sv */
// Constants, types and helpers shared by the time-code frame generator.
package itce_pkg;

  // ****************************************************************
  // Clock and symbol timing
  // ****************************************************************
  localparam int CLK_HZ = 10_000_000;
  localparam int US_PER_S = 1_000_000;
  localparam int SYM_PERIOD_US = 10_000;
  localparam int SYM_ZERO_US = 2_000;
  localparam int SYM_ONE_US = 5_000;
  localparam int SYM_MARK_US = 8_000;
  localparam int CNT_W = 17;

  // ****************************************************************
  // Register map and fields
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TIME = 8'h04;
  localparam logic [7:0] OFS_DATE = 8'h08;
  localparam logic [7:0] OFS_LOCAL = 8'h0c;
  localparam logic [7:0] OFS_LEAP = 8'h10;
  localparam logic [7:0] OFS_DST = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;
  localparam int CTRL_FMT_LSB = 0;
  localparam int CTRL_DC_BIT = 3;
  localparam int TIME_SEC_LSB = 0;
  localparam int TIME_MIN_LSB = 8;
  localparam int TIME_HR_LSB = 16;
  localparam int DATE_DAY_LSB = 0;
  localparam int DATE_YR_LSB = 16;
  localparam int LOC_LEAP_DEL_BIT = 0;
  localparam int LOC_DST_ON_BIT = 1;
  localparam int LOC_NEG_BIT = 2;
  localparam int LOC_OFS_HR_LSB = 3;
  localparam int LOC_HALF_BIT = 7;
  localparam int STAT_ACT_BIT = 7;
  localparam int STAT_QUAL_LSB = 8;
  localparam int CNTR_W = 16;

  // ****************************************************************
  // Frame layout
  // ****************************************************************
  localparam int FRAME_LEN = 100;
  localparam int SHORT_LEN = 25;
  localparam logic [6:0] MARK_STEP = 7'h0a;
  localparam logic [6:0] MARK_PHASE = 7'h09;
  localparam int POS_SEC_U = 1;
  localparam int POS_SEC_T = 6;
  localparam int POS_MIN_U = 10;
  localparam int POS_MIN_T = 15;
  localparam int POS_HR_U = 20;
  localparam int POS_HR_T = 25;
  localparam int POS_DAY_U = 30;
  localparam int POS_DAY_T = 35;
  localparam int POS_DAY_H = 40;
  localparam int POS_YR_U = 50;
  localparam int POS_YR_T = 55;
  localparam int POS_LEAP_PEND = 60;
  localparam int POS_LEAP_DEL = 61;
  localparam int POS_DST_PEND = 62;
  localparam int POS_DST_ON = 63;
  localparam int POS_OFS_SIGN = 64;
  localparam int POS_OFS_HR = 65;
  localparam int POS_OFS_HALF = 70;
  localparam int POS_QUAL = 71;
  localparam int POS_PARITY = 75;
  localparam int POS_SOD_LO = 80;
  localparam int POS_SOD_HI = 90;
  localparam int SOD_LO_W = 9;
  localparam int SOD_W = 17;
  localparam int SH_SEC = 1;
  localparam int SH_MIN = 8;
  localparam int SH_HR = 15;
  localparam logic [SOD_W-1:0] SEC_PER_MIN = 17'h0003c;
  localparam logic [SOD_W-1:0] SEC_PER_HR = 17'h00e10;
  localparam logic [CNTR_W-1:0] LEAP_WARN_S = 16'h003b;
  localparam logic [CNTR_W-1:0] DST_WARN_S = 16'h0001;

  // ****************************************************************
  // Time quality thresholds and codes
  // ****************************************************************
  localparam logic [31:0] ERR_1US_NS = 32'h0000_03e8;
  localparam logic [31:0] ERR_10US_NS = 32'h0000_2710;
  localparam logic [31:0] ERR_100US_NS = 32'h0001_86a0;
  localparam logic [31:0] ERR_1MS_NS = 32'h000f_4240;
  localparam logic [31:0] ERR_10MS_NS = 32'h0098_9680;
  localparam logic [3:0] QUAL_1US = 4'h4;
  localparam logic [3:0] QUAL_10US = 4'h5;
  localparam logic [3:0] QUAL_100US = 4'h6;
  localparam logic [3:0] QUAL_1MS = 4'h7;
  localparam logic [3:0] QUAL_10MS = 4'h8;
  localparam logic [3:0] QUAL_BAD = 4'h9;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    FMT_B122 = 3'h0,
    FMT_B123 = 3'h1,
    FMT_B120 = 3'h2,
    FMT_NASA = 3'h3,
    FMT_SHORT = 3'h4
  } itce_fmt_t;

  typedef enum logic [1:0] {
    SYM_ZERO = 2'h0,
    SYM_ONE = 2'h1,
    SYM_MARK = 2'h2
  } itce_sym_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_HIGH = 2'h1,
    ST_LOW = 2'h3
  } itce_state_t;

  localparam itce_fmt_t FMT_RST = FMT_B122;

  // Splits a binary value into three BCD digits, hundreds on top.
  function automatic logic [11:0] itce_bcd(input logic [8:0] v);
    logic [8:0] h;
    logic [8:0] t;
    logic [8:0] u;
    h = v / 9'h064;
    t = (v / 9'h00a) % 9'h00a;
    u = v % 9'h00a;
    return {h[3:0], t[3:0], u[3:0]};
  endfunction : itce_bcd

endpackage : itce_pkg

/* rtl/itce_sym_fifo.sv */
// Small symbol buffer between the frame builder and the serializer.
`timescale 1ns/1ns
module itce_sym_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 2
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // Full and empty come straight from the fill count.
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage holds no control state, so it needs no reset.
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers wrap naturally because the depth is a power of two.
  always_ff @(posedge mclk) begin
    if (rst || flush) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : itce_sym_fifo

/* testbench/itce_rx_model.sv */
// Receiver model that measures the high time of each code symbol.
`timescale 1ns/1ns
module itce_rx_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic code_in,
  output logic sym_valid,
  output int sym_width
);
  int hi_q;
  logic prev_q;
  // Count high cycles and report the width at each falling edge.
  always_ff @(posedge mclk) begin
    prev_q <= code_in;
    sym_valid <= 1'b0;
    if (rst) begin
      hi_q <= 0;
    end else if (code_in) begin
      hi_q <= hi_q + 1;
    end else if (prev_q) begin
      sym_valid <= 1'b1;
      sym_width <= hi_q;
      hi_q <= 0;
    end
  end
endmodule : itce_rx_model

/* testbench/irig_timecode_encoder_tb.sv */
// Self-checking bench for the time-code frame generator.
`timescale 1ns/1ns
module irig_timecode_encoder_tb;
  import itce_pkg::*;
  localparam int PC = 100;
  localparam int ZC = 20;
  localparam int OC = 50;
  localparam int MC = 80;
  logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pps_in = 0, ever_synced = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, time_error_ns = '0, rd, prdata;
  logic pready, pslverr, mod_o, dc_o, rx_v, err;
  int rx_w, fail_count = 0, check_count = 0, cyc = 0, dc_bad = 0;
  int fm, sc, mn, hr, dy, yr, lp, ds, del, dst, neg, ofs, half, q, den = 0;
  int wq[$];
  int errs[6] = '{500, 5000, 50000, 500000, 5000000, 50000000};
  int fmts[6] = '{2, 0, 1, 3, 4, 2};

  always #50 mclk = ~mclk;

  irig_timecode_encoder #(.PERIOD_CYC(PC), .ZERO_CYC(ZC), .ONE_CYC(OC), .MARK_CYC(MC)) dut_u (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pps_in(pps_in), .time_error_ns(time_error_ns), .ever_synced(ever_synced),
    .modulated_code_output(mod_o), .dc_code_output(dc_o));

  itce_rx_model rx_u (.mclk(mclk), .rst(rst), .code_in(mod_o), .sym_valid(rx_v),
    .sym_width(rx_w));

  // Collect symbol widths and cut a hung run short.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (rx_v) wq.push_back(rx_w);
    if (cyc == 90000) begin
      fail_count++;
      stop_test();
    end
  end

  // The level-shifted copy must follow the envelope when enabled.
  always @(negedge mclk) if (dc_o !== (mod_o & den[0])) dc_bad++;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // One APB transfer; waits for pready, whatever the latency.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb

  function automatic int qx();
    int t = 1000;
    if (!ever_synced) return 9;
    for (int k = 4; k < 9; k++) begin
      if (time_error_ns < t) return k;
      t = t * 10;
    end
    return 9;
  endfunction : qx

  // Expected symbol at a position: 0, 1 or 2 for a marker.
  function automatic int ex(int p);
    logic [99:0] b = '0;
    int sod = hr * 3600 + mn * 60 + sc;
    if (fm == 4) begin
      b[7:1] = {3'(sc / 10), 4'(sc % 10)};
      b[14:8] = {3'(mn / 10), 4'(mn % 10)};
      b[20:15] = {2'(hr / 10), 4'(hr % 10)};
      return p == 0 ? 2 : b[p];
    end
    if (p == 0 || p % 10 == 9) return 2;
    b[8:1] = {3'(sc / 10), 1'b0, 4'(sc % 10)};
    b[17:10] = {3'(mn / 10), 1'b0, 4'(mn % 10)};
    b[26:20] = {2'(hr / 10), 1'b0, 4'(hr % 10)};
    b[41:30] = {2'(dy / 100), 1'b0, 4'(dy / 10 % 10), 1'b0, 4'(dy % 10)};
    if (fm == 1 || fm == 2) b[97:80] = {8'(sod >> 9), 1'b0, 9'(sod)};
    if (fm == 2) begin
      b[58:50] = {4'(yr / 10), 1'b0, 4'(yr % 10)};
      b[64:60] = {1'(neg), 1'(dst), 1'(ds == 1), 1'(del), 1'(lp > 0 && lp < 60)};
      b[74:65] = {4'(q), 1'(half), 1'b0, 4'(ofs)};
      b[75] = ~^b[74:0];
    end
    return b[p];
  endfunction : ex

  function automatic int cls(int w);
    return w == ZC ? 0 : w == OC ? 1 : w == MC ? 2 : 3;
  endfunction : cls

  // Program one frame's fields, fire the second pulse, check every symbol.
  task automatic frame(input int i);
    int n;
    fm = fmts[i];
    sc = i == 0 ? 59 : $urandom % 60;
    mn = i == 0 ? 59 : $urandom % 60;
    hr = i == 0 ? 23 : $urandom % 24;
    dy = i == 0 ? 366 : 1 + $urandom % 366;
    yr = i == 0 ? 99 : $urandom % 100;
    lp = i == 0 ? 59 : $urandom % 70;
    ds = $urandom % 3;
    {del, dst, neg, half} = {$urandom % 2, $urandom % 2, $urandom % 2, $urandom % 2};
    ofs = $urandom % 16;
    ever_synced <= i > 0;
    // Frame 1 pins the finest error band so the sub-microsecond code is always seen.
    time_error_ns <= errs[i == 1 ? 0 : $urandom % 6];
    den = i % 2;
    apb(1, OFS_CTRL, den << 3 | fm);
    apb(1, OFS_TIME, hr << 16 | mn << 8 | sc);
    apb(1, OFS_DATE, yr << 16 | dy);
    apb(1, OFS_LOCAL, half << 7 | ofs << 3 | neg << 2 | dst << 1 | del);
    apb(1, OFS_LEAP, lp);
    apb(1, OFS_DST, ds);
    q = qx();
    apb(0, OFS_STAT, 0);
    chk("quality", rd[11:8], q);
    wq.delete();
    @(posedge mclk) pps_in <= 1;
    @(posedge mclk) pps_in <= 0;
    n = fm == 4 ? 25 : 100;
    while (wq.size() < n) @(posedge mclk);
    for (int p = 0; p < n; p++) begin
      chk("symbol", cls(wq[p]), ex(p));
    end
    repeat (150) @(posedge mclk);
    chk("length", wq.size(), n);
    chk("dc copy", dc_bad, 0);
  endtask : frame

  // Main sequence: reset checks, a refused access, then six frames covering all five formats.
  initial begin
    void'($urandom(32'ha6c7));
    repeat (12) @(posedge mclk);
    rst <= 0;
    @(posedge mclk);
    chk("idle output", mod_o, 0);
    apb(0, OFS_CTRL, 0);
    chk("ctrl reset", rd, 0);
    apb(0, OFS_STAT, 0);
    chk("quality reset", rd[11:8], 9);
    apb(0, 8'h40, 0);
    chk("unmapped err", err, 1);
    chk("unmapped data", rd, 0);
    for (int i = 0; i < 6; i++) frame(i);
    stop_test();
  end
endmodule : irig_timecode_encoder_tb
